/* logic/pil_regs.svh */
// Register offsets, field positions, reset values and timing figures for the channel 2 control block
`ifndef PIL_REGS_SVH
`define PIL_REGS_SVH

// Register offsets
`define PIL_PULSE_MOD_CFG_OFS 6'h16
`define PIL_CURRENT_LIMIT_CFG_OFS 6'h17

// Reset values
`define PIL_PULSE_MOD_CFG_RST 16'h0000
`define PIL_CURRENT_LIMIT_CFG_RST 16'h0088

// Pulse modulation register fields
`define PIL_RATE_MSB 11
`define PIL_RATE_LSB 9
`define PIL_DUTY_MSB 8
`define PIL_DUTY_LSB 1
`define PIL_MOD_EN_BIT 0
`define PIL_PULSE_RW_MASK 16'h0FFF

// Current limit register fields
`define PIL_PEAK_MSB 15
`define PIL_PEAK_LSB 14
`define PIL_MODE_MSB 13
`define PIL_MODE_LSB 12
`define PIL_WIRE_EN_BIT 11
`define PIL_INRUSH_MSB 10
`define PIL_INRUSH_LSB 8
`define PIL_SETTING_MSB 7
`define PIL_SETTING_LSB 4
`define PIL_STEADY_MSB 3
`define PIL_STEADY_LSB 0

// Clock rate in kHz and least on-time of a modulated period
`define PIL_CLK_KHZ 100000
`define PIL_MIN_ON_US 200

// Modulation frequencies in millihertz, codes 0 to 7
`define PIL_FREQ_MHZ_0 800
`define PIL_FREQ_MHZ_1 3400
`define PIL_FREQ_MHZ_2 13800
`define PIL_FREQ_MHZ_3 111000
`define PIL_FREQ_MHZ_4 221000
`define PIL_FREQ_MHZ_5 443000
`define PIL_FREQ_MHZ_6 885000
`define PIL_FREQ_MHZ_7 1770000

// Inrush durations in milliseconds, codes 0 to 7
`define PIL_INRUSH_MS_0 0
`define PIL_INRUSH_MS_1 2
`define PIL_INRUSH_MS_2 4
`define PIL_INRUSH_MS_3 6
`define PIL_INRUSH_MS_4 10
`define PIL_INRUSH_MS_5 20
`define PIL_INRUSH_MS_6 50
`define PIL_INRUSH_MS_7 100

`define PIL_PERIOD_W 27

`endif

/* logic/pil_pkg.sv */
// Types shared by the channel 2 modulation and inrush control block
package pil_pkg;

  // Capacitive charging modes
  typedef enum logic [1:0] {
    PIL_CHARGE_NONE = 2'b00,
    PIL_CHARGE_RAMP = 2'b01,
    PIL_CHARGE_REGULATE = 2'b10,
    PIL_CHARGE_PULSE = 2'b11
  } pil_charge_type;

  // Inrush timer states
  typedef enum logic [0:0] {
    PIL_T_IDLE = 1'b0,
    PIL_T_RUN = 1'b1
  } pil_timer_state_type;

endpackage : pil_pkg

/* logic/pil_pwm_core.sv */
// Period and duty counter producing the modulation level
`timescale 1ns/1ps
`include "pil_regs.svh"

module pil_pwm_core #(
  parameter int PERIOD_W = `PIL_PERIOD_W
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic [PERIOD_W-1:0] period_in,
  input wire logic [PERIOD_W-1:0] on_cycles_in,
  output logic level_out
);

  logic [PERIOD_W-1:0] count_reg;
  logic [PERIOD_W-1:0] count_next;
  logic level_next;
  wire logic wrap = (count_reg >= period_in - PERIOD_W'(1));

  // Counter restarts at each period boundary, held at zero when idle
  assign count_next = (!run_in || wrap) ? '0 : count_reg + PERIOD_W'(1);
  assign level_next = run_in && (count_next < on_cycles_in);

  // Counter and level flip-flops
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      count_reg <= '0;
      level_out <= 1'b0;
    end else begin
      count_reg <= count_next;
      level_out <= level_next;
    end
  end

endmodule : pil_pwm_core

/* logic/pil_inrush_timer.sv */
// Millisecond timer that marks the inrush period after switch-on
`timescale 1ns/1ps
`include "pil_regs.svh"

module pil_inrush_timer #(
  parameter int CLK_KHZ = `PIL_CLK_KHZ
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [2:0] code_in,
  output logic active_out
);

  localparam int PRE_W = $clog2(CLK_KHZ + 1);

  pil_pkg::pil_timer_state_type state_reg;
  pil_pkg::pil_timer_state_type state_next;
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic [6:0] ms_reg;
  logic [6:0] ms_next;
  logic [6:0] load_ms;
  wire logic ms_tick = (pre_reg == PRE_W'(CLK_KHZ - 1));

  // Duration lookup in milliseconds
  always_comb begin
    case (code_in)
      3'h0: load_ms = 7'(`PIL_INRUSH_MS_0);
      3'h1: load_ms = 7'(`PIL_INRUSH_MS_1);
      3'h2: load_ms = 7'(`PIL_INRUSH_MS_2);
      3'h3: load_ms = 7'(`PIL_INRUSH_MS_3);
      3'h4: load_ms = 7'(`PIL_INRUSH_MS_4);
      3'h5: load_ms = 7'(`PIL_INRUSH_MS_5);
      3'h6: load_ms = 7'(`PIL_INRUSH_MS_6);
      default: load_ms = 7'(`PIL_INRUSH_MS_7);
    endcase
  end

  // Countdown; a zero duration never enters the run state
  always_comb begin
    state_next = state_reg;
    pre_next = pre_reg;
    ms_next = ms_reg;
    case (state_reg)
      pil_pkg::PIL_T_IDLE: begin
        if (start_in && load_ms != 7'h00) begin
          state_next = pil_pkg::PIL_T_RUN;
          pre_next = '0;
          ms_next = load_ms;
        end
      end
      pil_pkg::PIL_T_RUN: begin
        pre_next = ms_tick ? '0 : pre_reg + PRE_W'(1);
        if (ms_tick) begin
          ms_next = ms_reg - 7'h01;
        end
        if (abort_in || (ms_tick && ms_reg == 7'h01)) begin
          state_next = pil_pkg::PIL_T_IDLE;
        end
      end
      default: state_next = pil_pkg::PIL_T_IDLE;
    endcase
  end

  // State flip-flops
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state_reg <= pil_pkg::PIL_T_IDLE;
      pre_reg <= '0;
      ms_reg <= 7'h00;
    end else begin
      state_reg <= state_next;
      pre_reg <= pre_next;
      ms_reg <= ms_next;
    end
  end

  assign active_out = (state_reg == pil_pkg::PIL_T_RUN);

endmodule : pil_inrush_timer

/* logic/pil_ch2_ctrl.sv */
// Channel 2 modulation, inrush and current-limit configuration control
//
// Summary of operation
// - Rate field bits 11:9 picks 0.8 to 1770 Hz modulation frequency.
// - Duty field bits 8:1 sets on-time in steps of 1/256 period.
// - Modulation enable accepted only if on-time exceeds 200 us, else error flagged.
// - Modulation enable refused unless charging mode is zero.
// - Enable clear: output follows switch; set: modulates only while switch on.
// - Charging mode bits 13:12: none, ramp, regulate, pulse.
// - During inrush with a charging mode, modulation and wire protection are suppressed.
// - Pulse mode: bits 15:14 pick pulse peak 47.5 to 70 A.
// - Bit 11 enables wire protection; it runs only after charging period.
// - Bits 10:8 set inrush duration 0 to 100 ms.
// - Mode zero: bits 7:4 are inrush overcurrent threshold code.
// - Regulate mode: bits 7:4 select regulation current, table value over five.
// - Pulse mode: bits 7:4 are pulse parameters, not a threshold.
// - Bits 3:0 set steady overcurrent threshold after inrush.
// - Current limit register resets to 0088h.
// - Wire fault sets on overcurrent while wire protection runs; clears on status read once gone.
`timescale 1ns/1ps
`include "pil_regs.svh"

module pil_ch2_ctrl #(
  parameter int CLK_KHZ = `PIL_CLK_KHZ
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic switch_on_command_in,
  input wire logic ch2_overcurrent_in,
  input wire logic ch2_fault_status_read_in,
  output logic [15:0] reg_rdata_out,
  output logic ch2_gate_on_out,
  output logic ch2_modulation_error_out,
  output logic ch2_wire_protect_fault_out,
  output logic ch2_wire_protect_run_out,
  output logic ch2_inrush_active_out,
  output logic [3:0] ch2_ocp_code_out,
  output logic [1:0] ch2_charge_mode_out,
  output logic [3:0] ch2_charge_setting_out,
  output logic [1:0] ch2_pulse_peak_limit_out,
  output logic ch2_ramp_code_ok_out
);

  localparam int PW = `PIL_PERIOD_W;
  localparam logic [PW-1:0] MIN_ON_CYC = PW'(`PIL_MIN_ON_US * CLK_KHZ / 1000);

  logic [15:0] pulse_cfg_reg;
  logic [15:0] pulse_cfg_next;
  logic [15:0] limit_cfg_reg;
  logic [15:0] limit_cfg_next;
  logic switch_q_reg;
  logic pwm_level;
  logic inrush_active;

  // Period in clock cycles for a rate code, 64-bit to keep the product exact
  function automatic logic [PW-1:0] period_of(input logic [2:0] code);
    logic [63:0] mhz;
    case (code)
      3'h0: mhz = 64'(`PIL_FREQ_MHZ_0);
      3'h1: mhz = 64'(`PIL_FREQ_MHZ_1);
      3'h2: mhz = 64'(`PIL_FREQ_MHZ_2);
      3'h3: mhz = 64'(`PIL_FREQ_MHZ_3);
      3'h4: mhz = 64'(`PIL_FREQ_MHZ_4);
      3'h5: mhz = 64'(`PIL_FREQ_MHZ_5);
      3'h6: mhz = 64'(`PIL_FREQ_MHZ_6);
      default: mhz = 64'(`PIL_FREQ_MHZ_7);
    endcase
    period_of = PW'((64'(CLK_KHZ) * 64'h0000_0000_000F_4240) / mhz);
  endfunction : period_of

  // On-time of a period: period times duty over 256
  function automatic logic [PW-1:0] on_of(input logic [PW-1:0] per, input logic [7:0] duty);
    logic [PW+7:0] prod;
    prod = (PW+8)'(per) * (PW+8)'(duty);
    on_of = prod[PW+7:8];
  endfunction : on_of

  // Stored field views
  wire logic [2:0] rate_select = pulse_cfg_reg[`PIL_RATE_MSB:`PIL_RATE_LSB];
  wire logic [7:0] duty_code = pulse_cfg_reg[`PIL_DUTY_MSB:`PIL_DUTY_LSB];
  wire logic modulation_enable = pulse_cfg_reg[`PIL_MOD_EN_BIT];
  wire logic [1:0] pulse_peak_limit = limit_cfg_reg[`PIL_PEAK_MSB:`PIL_PEAK_LSB];
  wire logic [1:0] charge_mode = limit_cfg_reg[`PIL_MODE_MSB:`PIL_MODE_LSB];
  wire logic wire_protect_enable = limit_cfg_reg[`PIL_WIRE_EN_BIT];
  wire logic [2:0] inrush_time = limit_cfg_reg[`PIL_INRUSH_MSB:`PIL_INRUSH_LSB];
  wire logic [3:0] inrush_setting = limit_cfg_reg[`PIL_SETTING_MSB:`PIL_SETTING_LSB];
  wire logic [3:0] steady_current_limit = limit_cfg_reg[`PIL_STEADY_MSB:`PIL_STEADY_LSB];

  wire logic charge_none = (charge_mode == pil_pkg::PIL_CHARGE_NONE);
  wire logic [PW-1:0] period_cyc = period_of(rate_select);
  wire logic [PW-1:0] on_cyc = on_of(period_cyc, duty_code);

  // Write decode; the check uses the duty and rate being written, not the old ones
  wire logic wr_pulse = reg_write_in && (reg_addr_in == `PIL_PULSE_MOD_CFG_OFS);
  wire logic wr_limit = reg_write_in && (reg_addr_in == `PIL_CURRENT_LIMIT_CFG_OFS);
  wire logic [PW-1:0] wr_on_cyc = on_of(period_of(reg_wdata_in[`PIL_RATE_MSB:`PIL_RATE_LSB]),
                                        reg_wdata_in[`PIL_DUTY_MSB:`PIL_DUTY_LSB]);
  wire logic wr_on_ok = (wr_on_cyc > MIN_ON_CYC);
  wire logic en_req = wr_pulse && reg_wdata_in[`PIL_MOD_EN_BIT];
  wire logic en_ok = wr_on_ok && charge_none;
  wire logic en_refused = en_req && !en_ok;

  // Enable bit stores only an accepted request; reserved upper bits stay zero
  assign pulse_cfg_next = wr_pulse ?
    ((reg_wdata_in & `PIL_PULSE_RW_MASK & ~16'h0001) | {15'h0000, en_req && en_ok}) : pulse_cfg_reg;
  assign limit_cfg_next = wr_limit ? reg_wdata_in : limit_cfg_reg;

  // Inrush starts on each switch-on edge with a nonzero duration code and ends early if the switch drops
  wire logic switch_rise = switch_on_command_in && !switch_q_reg;
  // The switch-on edge counts as charging too; the timer only shows it a cycle later
  wire logic charging_now = (inrush_active || (switch_rise && (inrush_time != 3'h0))) && !charge_none;
  wire logic mod_run = modulation_enable && switch_on_command_in && !charging_now;

  pil_inrush_timer #(
    .CLK_KHZ(CLK_KHZ)
  ) u_inrush (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .start_in(switch_rise),
    .abort_in(!switch_on_command_in),
    .code_in(inrush_time),
    .active_out(inrush_active)
  );

  pil_pwm_core #(
    .PERIOD_W(PW)
  ) u_pwm (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .run_in(mod_run),
    .period_in(period_cyc),
    .on_cycles_in(on_cyc),
    .level_out(pwm_level)
  );

  // Output level: plain follow unless modulating
  wire logic gate_next = switch_on_command_in && (!mod_run || pwm_level);
  // Wire protection counts only once any charging period is over
  wire logic wire_run_next = wire_protect_enable && switch_on_command_in && !charging_now;
  // Sticky fault, set beats the read-clear
  wire logic wire_set = ch2_wire_protect_run_out && ch2_overcurrent_in;
  wire logic wire_clr = ch2_fault_status_read_in && !ch2_overcurrent_in;
  wire logic wire_fault_next = wire_set || (ch2_wire_protect_fault_out && !wire_clr);
  wire logic err_next = en_refused || (ch2_modulation_error_out && !ch2_fault_status_read_in);
  // Threshold in force: inrush code only without a charging mode
  wire logic [3:0] ocp_next = (inrush_active && charge_none) ? inrush_setting : steady_current_limit;
  // Ramp codes with a defined rate
  wire logic ramp_ok_next = (charge_mode == pil_pkg::PIL_CHARGE_RAMP) && (inrush_setting inside
    {4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD});
  // Read mux; unmapped offsets answer zero
  wire logic [15:0] rdata_next = !reg_read_in ? 16'h0000 :
    (reg_addr_in == `PIL_PULSE_MOD_CFG_OFS) ? pulse_cfg_reg :
    (reg_addr_in == `PIL_CURRENT_LIMIT_CFG_OFS) ? limit_cfg_reg : 16'h0000;

  // Configuration registers
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pulse_cfg_reg <= `PIL_PULSE_MOD_CFG_RST;
      limit_cfg_reg <= `PIL_CURRENT_LIMIT_CFG_RST;
    end else begin
      pulse_cfg_reg <= pulse_cfg_next;
      limit_cfg_reg <= limit_cfg_next;
    end
  end

  // Status and control outputs, all registered
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      switch_q_reg <= 1'b0;
      reg_rdata_out <= 16'h0000;
      ch2_gate_on_out <= 1'b0;
      ch2_modulation_error_out <= 1'b0;
      ch2_wire_protect_fault_out <= 1'b0;
      ch2_wire_protect_run_out <= 1'b0;
      ch2_inrush_active_out <= 1'b0;
      ch2_ocp_code_out <= 4'h8;
      ch2_charge_mode_out <= 2'h0;
      ch2_charge_setting_out <= 4'h8;
      ch2_pulse_peak_limit_out <= 2'h0;
      ch2_ramp_code_ok_out <= 1'b0;
    end else begin
      switch_q_reg <= switch_on_command_in;
      reg_rdata_out <= rdata_next;
      ch2_gate_on_out <= gate_next;
      ch2_modulation_error_out <= err_next;
      ch2_wire_protect_fault_out <= wire_fault_next;
      ch2_wire_protect_run_out <= wire_run_next;
      ch2_inrush_active_out <= inrush_active;
      ch2_ocp_code_out <= ocp_next;
      ch2_charge_mode_out <= charge_mode;
      ch2_charge_setting_out <= inrush_setting;
      ch2_pulse_peak_limit_out <= (charge_mode == pil_pkg::PIL_CHARGE_PULSE) ? pulse_peak_limit : 2'h0;
      ch2_ramp_code_ok_out <= ramp_ok_next;
    end
  end

  // Checks on the outputs against their causes
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  AST_GATE_OFF: assert property (
    !switch_on_command_in |=> !ch2_gate_on_out)
    else $error("gate on while switch command off");

  AST_GATE_FOLLOW: assert property (
    (switch_on_command_in && !modulation_enable) |=> ch2_gate_on_out)
    else $error("gate does not follow switch command");

  AST_MODE_REFUSE: assert property (
    (en_req && !charge_none) |=> !modulation_enable ##1 !modulation_enable)
    else $error("modulation enabled with charging mode set");

  AST_SHORT_ON_ERR: assert property (
    (en_req && !wr_on_ok) |=> (ch2_modulation_error_out && !modulation_enable))
    else $error("short on-time not flagged");

  AST_ACCEPT: assert property (
    (en_req && wr_on_ok && charge_none) |=> (modulation_enable && !$rose(ch2_modulation_error_out)))
    else $error("valid enable not stored");

  AST_LIMIT_RESET: assert property (
    $rose(rstn_in) |-> (limit_cfg_reg == 16'h0088))
    else $error("current limit register reset value wrong");

  AST_WIRE_HOLD: assert property (
    (charging_now) |=> !ch2_wire_protect_run_out)
    else $error("wire protection runs during charging");

  AST_WIRE_SET: assert property (
    (ch2_wire_protect_run_out && ch2_overcurrent_in) |=> ch2_wire_protect_fault_out)
    else $error("wire fault not set");

  AST_WIRE_KEEP: assert property (
    (ch2_wire_protect_fault_out && !(ch2_fault_status_read_in && !ch2_overcurrent_in)) |=> ch2_wire_protect_fault_out)
    else $error("wire fault lost without clear");

  AST_OCP_INRUSH: assert property (
    (inrush_active && charge_none) |=> (ch2_ocp_code_out == $past(inrush_setting)))
    else $error("inrush threshold not applied");

  AST_OCP_STEADY: assert property (
    !inrush_active |=> (ch2_ocp_code_out == $past(steady_current_limit)))
    else $error("steady threshold not applied");

  AST_NO_MOD_CHARGING: assert property (
    (charging_now && switch_on_command_in) |=> ch2_gate_on_out)
    else $error("output modulated during charging");

  AST_CHARGE_START: assert property (
    (switch_rise && !charge_none && (inrush_time != 3'h0)) |=> (ch2_gate_on_out && !ch2_wire_protect_run_out))
    else $error("modulation or wire protection at charging start");

  AST_PEAK_MODE: assert property (
    (charge_mode != pil_pkg::PIL_CHARGE_PULSE) |=> (ch2_pulse_peak_limit_out == 2'h0))
    else $error("pulse peak passed outside pulse mode");

  AST_PEAK_PASS: assert property (
    (charge_mode == pil_pkg::PIL_CHARGE_PULSE) |=> (ch2_pulse_peak_limit_out == $past(pulse_peak_limit)))
    else $error("pulse peak not passed in pulse mode");

  AST_RAMP_OFF: assert property (
    (charge_mode != pil_pkg::PIL_CHARGE_RAMP) |=> !ch2_ramp_code_ok_out)
    else $error("ramp code valid outside ramp mode");

  AST_SETTING_REGULATE: assert property (
    (charge_mode == pil_pkg::PIL_CHARGE_REGULATE) |=> (ch2_charge_setting_out == $past(inrush_setting)))
    else $error("regulation code not passed");

  AST_SETTING_PULSE: assert property (
    (charge_mode == pil_pkg::PIL_CHARGE_PULSE) |=> (ch2_charge_setting_out == $past(inrush_setting)))
    else $error("pulse parameters not passed");

  AST_MODE_OUT: assert property (
    1'b1 |=> (ch2_charge_mode_out == $past(charge_mode)))
    else $error("charging mode output wrong");

  AST_ERR_CLEAR: assert property (
    (ch2_fault_status_read_in && !en_refused) |=> !ch2_modulation_error_out)
    else $error("modulation error not cleared by status read");

  AST_WIRE_CLEAR: assert property (
    (ch2_fault_status_read_in && !ch2_overcurrent_in) |=> !ch2_wire_protect_fault_out)
    else $error("wire fault not cleared");

  AST_WIRE_ONLY_RUN: assert property (
    !(ch2_wire_protect_run_out && ch2_overcurrent_in) |=> !$rose(ch2_wire_protect_fault_out))
    else $error("wire fault set without running protection");

  AST_WIRE_RUN_EN: assert property (
    !wire_protect_enable |=> !ch2_wire_protect_run_out)
    else $error("wire protection runs while disabled");

  AST_INRUSH_ABORT: assert property (
    !switch_on_command_in |=> !inrush_active)
    else $error("inrush continues with switch off");

  COV_MODULATE: cover property (mod_run && pwm_level ##1 !pwm_level);
  COV_REFUSED: cover property (en_refused);
  COV_ACCEPTED: cover property (en_req && en_ok);
  COV_INRUSH: cover property ($rose(inrush_active) ##[1:20] $fell(inrush_active));
  COV_WIRE_FAULT: cover property ($rose(ch2_wire_protect_fault_out));

endmodule : pil_ch2_ctrl

/* tb/pil_host_model.sv */
// Host model driving the channel 2 register port and fault status reads
`timescale 1ns/1ps
`include "pil_regs.svh"

module pil_host_model (
  input wire logic clock_in,
  input wire logic [15:0] rdata_in,
  output logic [5:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] wdata_out,
  output logic stat_rd_out
);
  // Idle bus at time zero
  initial begin
    addr_out = 6'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0000;
    stat_rd_out = 1'b0;
  end

  // One write; steady codes above Ch are never sent
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] w;
    w = d;
    if (a == `PIL_CURRENT_LIMIT_CFG_OFS && d[3:0] > 4'hC) w[3:0] = 4'hC;
    @(posedge clock_in);
    #1;
    addr_out = a;
    wdata_out = w;
    wr_out = 1'b1;
    @(posedge clock_in);
    #1;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : wr

  // One read; data is taken the cycle after the request
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clock_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clock_in);
    #1;
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : rd

  // Fault status register read pulse
  task automatic stat;
    @(posedge clock_in);
    #1;
    stat_rd_out = 1'b1;
    @(posedge clock_in);
    #1;
    stat_rd_out = 1'b0;
  endtask : stat
endmodule : pil_host_model

/* tb/pil_ch2_ctrl_test.sv */
// Self-checking bench for the channel 2 modulation and inrush control
`timescale 1ns/1ps
`include "pil_regs.svh"

module pil_ch2_ctrl_test;
  // Short millisecond keeps inrush and periods cheap
  localparam int KHZ = 10;
  localparam logic [5:0] PM = `PIL_PULSE_MOD_CFG_OFS;
  localparam logic [5:0] CL = `PIL_CURRENT_LIMIT_CFG_OFS;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic sw = 1'b0;
  logic oc = 1'b0;
  logic [15:0] rdata;
  logic [5:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic stat_rd;
  logic gate;
  logic mod_err;
  logic wp_fault;
  logic wp_run;
  logic inrush;
  logic [3:0] ocp;
  logic [1:0] mode;
  logic [3:0] setting;
  logic [1:0] peak;
  logic ramp_ok;
  logic [15:0] v;
  int num_errors = 0;
  int num_checks = 0;
  int k;

  pil_host_model i_host (.clock_in(clock), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata), .stat_rd_out(stat_rd));

  pil_ch2_ctrl #(.CLK_KHZ(KHZ)) i_dut (.clock_in(clock), .rstn_in(rstn), .reg_addr_in(addr),
    .reg_write_in(wr), .reg_read_in(rd), .reg_wdata_in(wdata), .switch_on_command_in(sw),
    .ch2_overcurrent_in(oc), .ch2_fault_status_read_in(stat_rd), .reg_rdata_out(rdata),
    .ch2_gate_on_out(gate), .ch2_modulation_error_out(mod_err), .ch2_wire_protect_fault_out(wp_fault),
    .ch2_wire_protect_run_out(wp_run), .ch2_inrush_active_out(inrush), .ch2_ocp_code_out(ocp),
    .ch2_charge_mode_out(mode), .ch2_charge_setting_out(setting), .ch2_pulse_peak_limit_out(peak),
    .ch2_ramp_code_ok_out(ramp_ok));

  // 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Counting over a whole period makes the result independent of phase
  task automatic count_high(input int n, output int c);
    c = 0;
    repeat (n) begin
      tick(1);
      if (gate === 1'b1) c++;
    end
  endtask : count_high

  task automatic t_reset;
    i_host.rd(PM, v);
    chk("pulse cfg", v, 16'h0000);
    i_host.rd(CL, v);
    chk("limit cfg", v, 16'h0088);
    chk("ocp", {12'h0, ocp}, 16'h0008);
    chk("setting", {12'h0, setting}, 16'h0008);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    i_host.wr(PM, 16'hFFFE);
    i_host.rd(PM, v);
    chk("pulse cfg", v, 16'h0FFE);
    for (int m = 0; m < 4; m++) begin
      i_host.wr(CL, {2'h3, m[1:0], 12'h738});
      tick(2);
      chk("mode", {14'h0, mode}, m[15:0]);
      chk("peak", {14'h0, peak}, (m == 3) ? 16'h0003 : 16'h0000);
      chk("ramp ok", {15'h0, ramp_ok}, (m == 1) ? 16'h0001 : 16'h0000);
      chk("setting", {12'h0, setting}, 16'h0003);
    end
    i_host.wr(CL, 16'h1048);
    tick(2);
    chk("ramp ok", {15'h0, ramp_ok}, 16'h0000);
    i_host.wr(CL, 16'hEBC5);
    i_host.wr(6'h18, 16'hFFFF);
    i_host.rd(CL, v);
    chk("limit cfg", v, 16'hEBC5);
    chk("ocp", {12'h0, ocp}, 16'h0005);
    i_host.rd(6'h18, v);
    chk("unmapped", v, 16'h0000);
    i_host.wr(CL, 16'h0088);
    i_host.wr(PM, 16'h0000);
    $display("test registers done");
  endtask : t_regs

  // Rate 3 gives 90 cycles: duty 8 is 2 on-cycles, duty 9 is 3
  task automatic t_refuse;
    i_host.wr(PM, 16'h0611);
    tick(2);
    i_host.rd(PM, v);
    chk("refused enable", v, 16'h0610);
    chk("mod error", {15'h0, mod_err}, 16'h0001);
    i_host.stat();
    tick(2);
    chk("mod error", {15'h0, mod_err}, 16'h0000);
    i_host.wr(PM, 16'h0613);
    i_host.rd(PM, v);
    chk("accepted enable", v, 16'h0613);
    i_host.wr(PM, 16'h0000);
    i_host.wr(CL, 16'h1088);
    i_host.wr(PM, 16'h0613);
    i_host.rd(PM, v);
    chk("mode refusal", v, 16'h0612);
    chk("mod error", {15'h0, mod_err}, 16'h0001);
    i_host.stat();
    i_host.wr(CL, 16'h0088);
    i_host.wr(PM, 16'h0000);
    $display("test refusal done");
  endtask : t_refuse

  task automatic t_follow;
    sw = 1'b1;
    tick(3);
    chk("gate on", {15'h0, gate}, 16'h0001);
    sw = 1'b0;
    tick(3);
    chk("gate off", {15'h0, gate}, 16'h0000);
    $display("test follow done");
  endtask : t_follow

  task automatic t_pwm;
    int per [8] = '{12500, 2941, 724, 90, 45, 22, 11, 5};
    int on [8] = '{12451, 2929, 721, 89, 44, 21, 10, 4};
    for (int c = 0; c < 8; c++) begin
      i_host.wr(PM, {4'h0, c[2:0], 8'hFF, 1'b1});
      sw = 1'b1;
      tick(8);
      count_high(per[c], k);
      chk("on cycles", k[15:0], on[c][15:0]);
      sw = 1'b0;
      tick(3);
    end
    chk("mod error", {15'h0, mod_err}, 16'h0000);
    i_host.wr(PM, 16'h0000);
    $display("test modulation done");
  endtask : t_pwm

  // Durations are 10 cycles per millisecond here
  task automatic t_inrush;
    int ms [8] = '{0, 2, 4, 6, 10, 20, 50, 100};
    for (int c = 0; c < 8; c++) begin
      i_host.wr(CL, {5'h00, c[2:0], 8'h52});
      sw = 1'b1;
      tick(1);
      if (ms[c] > 0) begin
        tick(ms[c] * KHZ - 4);
        chk("inrush on", {15'h0, inrush}, 16'h0001);
        chk("inrush ocp", {12'h0, ocp}, 16'h0005);
      end
      tick(8);
      chk("inrush off", {15'h0, inrush}, 16'h0000);
      chk("steady ocp", {12'h0, ocp}, 16'h0002);
      sw = 1'b0;
      tick(2);
    end
    $display("test inrush done");
  endtask : t_inrush

  task automatic t_charge;
    int bad;
    i_host.wr(CL, 16'h0088);
    i_host.wr(PM, 16'h0701);
    i_host.wr(CL, 16'h2958);
    sw = 1'b1;
    tick(1);
    chk("charge ocp", {12'h0, ocp}, 16'h0008);
    bad = 0;
    repeat (15) begin
      if (gate !== 1'b1 || wp_run !== 1'b0) bad++;
      tick(1);
    end
    chk("suppressed", bad[15:0], 16'h0000);
    tick(12);
    chk("wire run", {15'h0, wp_run}, 16'h0001);
    count_high(90, k);
    chk("on cycles", k[15:0], 16'd45);
    sw = 1'b0;
    i_host.wr(CL, 16'h0088);
    i_host.wr(PM, 16'h0000);
    $display("test charging done");
  endtask : t_charge

  task automatic t_fault;
    sw = 1'b1;
    oc = 1'b1;
    tick(5);
    chk("fault off", {15'h0, wp_fault}, 16'h0000);
    chk("run off", {15'h0, wp_run}, 16'h0000);
    i_host.wr(CL, 16'h0888);
    tick(3);
    chk("fault set", {15'h0, wp_fault}, 16'h0001);
    i_host.stat();
    tick(2);
    chk("fault held", {15'h0, wp_fault}, 16'h0001);
    oc = 1'b0;
    i_host.stat();
    tick(2);
    chk("fault clear", {15'h0, wp_fault}, 16'h0000);
    sw = 1'b0;
    $display("test wire fault done");
  endtask : t_fault

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // Main sequence, reset held for four cycles
  initial begin
    tick(4);
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_refuse();
    t_follow();
    t_pwm();
    t_inrush();
    t_charge();
    t_fault();
    end_sim();
  end

  // Tests need about 20k cycles; twice that means a hang
  initial begin
    #400000;
    num_errors++;
    $display("unexpected timeout: expected end, seen none");
    end_sim();
  end
endmodule : pil_ch2_ctrl_test
